//--- abs_seq.v
// alu branch sequencer: condition evaluation and pc redirection
// Contract
// - no condition means sequential flow only
// - result tests: neg, nonneg, zero, notpos, nonzero
// - one condition true when overflow clear
// - compare tests first source against second
// - taken: slot, skip two, go target
// - not taken, plain: discard target, fetch fall-through
// - not taken, plain: two stall cycles
// - always-execute bit set suppresses discard
// - always-execute taken order equals plain taken order
// - always-execute not taken: target pair, then fall-through
// - committed slot always executes
// - target fixed at four past branch
// - zero tests use modulo field only when modulo is set, full width otherwise
// - overflow updated only by full-width add/sub
`timescale 1ns/100ps
`include "abs_map.vh"

module abs_seq (
  input  wire                 i_clk_sys,
  input  wire                 i_sys_rst,
  input  wire                 i_exec_valid,
  input  wire [`ABS_AW-1:0]   i_exec_pc,
  input  wire                 i_exec_is_cmp,
  input  wire [`ABS_CW-1:0]   i_exec_cond,
  input  wire                 i_exec_always_execute_bit,
  input  wire [`ABS_DW-1:0]   i_exec_result,
  input  wire [`ABS_DW-1:0]   i_exec_src_a,
  input  wire [`ABS_DW-1:0]   i_exec_src_b,
  input  wire [`ABS_DW-1:0]   i_exec_mod_mask,
  input  wire                 i_exec_is_addsub,
  input  wire                 i_exec_modulo,
  input  wire                 i_exec_ovf,
  output reg                  o_redirect,
  output reg  [`ABS_AW-1:0]   o_redirect_pc,
  output reg                  o_discard,
  output reg                  o_stall,
  output reg                  o_taken,
  output reg                  o_ovf_flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 4'b0001;
  localparam ST_SLOT  = 4'b0010;
  localparam ST_STALL = 4'b0100;
  localparam ST_KEEP  = 4'b1000;
  reg  [3:0]          state;
  reg  [3:0]          next_state;
  reg                 pend_fall;
  reg                 pend_keep;
  reg  [`ABS_AW-1:0]  pend_pc;
  reg                 stall_cnt;

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------
  wire [`ABS_DW-1:0] zmask  = i_exec_modulo ? i_exec_mod_mask : `ABS_FULL_MASK;
  wire               zero   = ((i_exec_result & zmask) == `ABS_ZERO_WORD);
  wire               neg    = i_exec_result[`ABS_DW-1];
  wire signed [`ABS_DW-1:0] sa = i_exec_src_a;
  wire signed [`ABS_DW-1:0] sb = i_exec_src_b;
  reg                cond_true;
  always @* begin
    cond_true = 1'b0;
    if (i_exec_is_cmp) begin
      case (i_exec_cond)
        `ABS_K_GT: cond_true = sa > sb;
        `ABS_K_GE: cond_true = sa >= sb;
        `ABS_K_EQ: cond_true = sa == sb;
        `ABS_K_LE: cond_true = sa <= sb;
        `ABS_K_LT: cond_true = sa < sb;
        `ABS_K_NE: cond_true = sa != sb;
        default:   cond_true = 1'b0;
      endcase
    end else begin
      case (i_exec_cond)
        `ABS_C_NEG:       cond_true = neg;
        `ABS_C_NONNEG:    cond_true = ~neg;
        `ABS_C_ZERO:      cond_true = zero;
        `ABS_C_NOTPOS:    cond_true = neg | zero;
        `ABS_C_NONZERO:   cond_true = ~zero;
        `ABS_C_OVF_CLEAR: cond_true = ~o_ovf_flag;
        default:          cond_true = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decode of the current cycle
  // ----------------------------------------------------------------
  wire                is_branch  = i_exec_valid && (i_exec_cond != `ABS_C_NONE) &&
                                   (state == ST_IDLE);
  wire                slot_done  = (state == ST_SLOT) && i_exec_valid;
  wire                go_stall   = slot_done && pend_fall;
  wire                go_keep    = slot_done && pend_keep;
  wire                stall_more = (state == ST_STALL) && (stall_cnt != `ABS_STALL_LAST);
  wire [`ABS_AW-1:0]  target_pc  = i_exec_pc + `ABS_TARGET_OFS;
  wire [`ABS_AW-1:0]  fall_pc    = i_exec_pc + `ABS_FALL_OFS;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (is_branch)
          next_state = ST_SLOT;
      end
      ST_SLOT: begin
        if (go_stall)
          next_state = ST_STALL;
        else if (go_keep)
          next_state = ST_KEEP;
        else if (i_exec_valid)
          next_state = ST_IDLE;
      end
      ST_STALL: begin
        if (stall_cnt == `ABS_STALL_LAST)
          next_state = ST_IDLE;
      end
      ST_KEEP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // pending decision of the branch in flight
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pend_fall <= 1'b0;
      pend_keep <= 1'b0;
      pend_pc   <= `ABS_PC_RST;
    end else if (is_branch) begin
      pend_fall <= !cond_true && !i_exec_always_execute_bit;
      pend_keep <= !cond_true && i_exec_always_execute_bit;
      pend_pc   <= fall_pc;
    end
  end

  // ----------------------------------------------------------------
  // stall counter
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      stall_cnt <= 1'b0;
    end else if (go_stall) begin
      stall_cnt <= 1'b0;
    end else if (state == ST_STALL) begin
      stall_cnt <= `ABS_STALL_LAST;
    end
  end

  // ----------------------------------------------------------------
  // stored overflow flag
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_ovf_flag <= 1'b0;
    end else if (i_exec_valid && i_exec_is_addsub && !i_exec_modulo) begin
      o_ovf_flag <= i_exec_ovf;
    end
  end

  // ----------------------------------------------------------------
  // condition result
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_taken <= 1'b0;
    end else begin
      o_taken <= is_branch && cond_true;
    end
  end

  // ----------------------------------------------------------------
  // fetch redirection
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_redirect    <= 1'b0;
      o_redirect_pc <= `ABS_PC_RST;
    end else if (is_branch && (cond_true || i_exec_always_execute_bit)) begin
      o_redirect    <= 1'b1;
      o_redirect_pc <= target_pc;
    end else if (go_stall) begin
      o_redirect    <= 1'b1;
      o_redirect_pc <= pend_pc;
    end else if (state == ST_KEEP) begin
      o_redirect    <= 1'b1;
      o_redirect_pc <= pend_pc;
    end else begin
      o_redirect    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // discard and stall
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_discard <= 1'b0;
      o_stall   <= 1'b0;
    end else begin
      o_discard <= go_stall;
      o_stall   <= go_stall || stall_more;
    end
  end

endmodule

//--- abs_map.vh
// constants for the alu branch sequencer
`ifndef ABS_MAP_VH
`define ABS_MAP_VH
`define ABS_DW            16
`define ABS_AW            16
`define ABS_CW            3
// non-compare condition codes
`define ABS_C_NONE        3'h0
`define ABS_C_NEG         3'h1
`define ABS_C_NONNEG      3'h2
`define ABS_C_ZERO        3'h3
`define ABS_C_NOTPOS      3'h4
`define ABS_C_NONZERO     3'h5
`define ABS_C_OVF_CLEAR   3'h6
// compare condition codes
`define ABS_K_NONE        3'h0
`define ABS_K_GT          3'h1
`define ABS_K_GE          3'h2
`define ABS_K_EQ          3'h3
`define ABS_K_LE          3'h4
`define ABS_K_LT          3'h5
`define ABS_K_NE          3'h6
// fixed target distance and fall-through offsets
`define ABS_TARGET_OFS    16'h0004
`define ABS_FALL_OFS      16'h0002
`define ABS_NEXT_OFS      16'h0001
`define ABS_PC_RST        16'h0000
// full-width zero test and stall counter end value
`define ABS_FULL_MASK     16'hffff
`define ABS_ZERO_WORD     16'h0000
`define ABS_STALL_LAST    1'b1
`endif

//--- abs_seq_chk.sv
// assertions for the alu branch sequencer
`timescale 1ns/100ps
module abs_seq_chk(input wire i_clk_sys, i_sys_rst, i_exec_valid, i_exec_is_cmp,
  i_exec_always_execute_bit, i_exec_modulo, i_exec_is_addsub, o_redirect, o_discard,
  o_stall, o_taken, o_ovf_flag, input wire [2:0] i_exec_cond,
  input wire [15:0] i_exec_pc, i_exec_result, i_exec_src_a, i_exec_src_b, i_exec_mod_mask,
  o_redirect_pc);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  reg pb;
  reg pa;
  reg pk;
  wire [2:0] c = i_exec_cond;
  wire k = i_exec_is_cmp;
  wire br = i_exec_valid && c != 3'h0 && !pb && !pk && !o_stall;
  wire z = (i_exec_result & (i_exec_modulo ? i_exec_mod_mask : 16'hffff)) == 16'h0;
  wire g = $signed(i_exec_src_a) > $signed(i_exec_src_b);
  always @(posedge i_clk_sys) pb <= !i_sys_rst && i_exec_valid && c != 3'h0;
  always @(posedge i_clk_sys) pa <= !i_sys_rst && br && i_exec_always_execute_bit;
  always @(posedge i_clk_sys) pk <= !i_sys_rst && pa && !o_taken;
  property p_plain; i_exec_valid && c == 3'h0 && !pb && !pk |=> !o_redirect && !o_taken;
  endproperty
  a_plain: assert property (p_plain) else $error("plain redirect");
  property p_zero; br && !k && c == 3'h3 |=> o_taken == $past(z); endproperty
  a_zero: assert property (p_zero) else $error("zero test");
  property p_ovf; br && !k && c == 3'h6 |=> o_taken != $past(o_ovf_flag); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow test");
  property p_gt; br && k && c == 3'h1 |=> o_taken == $past(g); endproperty
  a_gt: assert property (p_gt) else $error("compare test");
  property p_go; br ##1 o_taken |-> o_redirect && o_redirect_pc == $past(i_exec_pc) + 16'h4
    ##1 !o_stall; endproperty
  a_go: assert property (p_go) else $error("taken path");
  property p_drop; br && !i_exec_always_execute_bit ##1 !o_taken |=> o_discard && o_stall &&
    o_redirect && o_redirect_pc == $past(i_exec_pc, 2) + 16'h2 ##1 o_stall ##1 !o_stall;
  endproperty
  a_drop: assert property (p_drop) else $error("drop path");
  property p_keep; br && i_exec_always_execute_bit ##1 !o_taken |-> o_redirect &&
    o_redirect_pc == $past(i_exec_pc) + 16'h4 ##1 !o_discard && !o_stall ##1 o_redirect &&
    !o_stall && o_redirect_pc == $past(i_exec_pc, 3) + 16'h2; endproperty
  a_keep: assert property (p_keep) else $error("keep path");
  property p_slot; br |=> !o_discard && !o_stall; endproperty
  a_slot: assert property (p_slot) else $error("slot held");
  property p_flag; i_exec_valid && (!i_exec_is_addsub || i_exec_modulo) |=>
    $stable(o_ovf_flag); endproperty
  a_flag: assert property (p_flag) else $error("flag changed");
  cover property (br ##1 o_taken);
  cover property (br ##2 o_discard);
  cover property (br && i_exec_always_execute_bit ##1 !o_taken);
endmodule
bind abs_seq abs_seq_chk u_chk (
  .i_clk_sys                 (i_clk_sys),
  .i_sys_rst                 (i_sys_rst),
  .i_exec_valid              (i_exec_valid),
  .i_exec_is_cmp             (i_exec_is_cmp),
  .i_exec_always_execute_bit (i_exec_always_execute_bit),
  .i_exec_modulo             (i_exec_modulo),
  .i_exec_is_addsub          (i_exec_is_addsub),
  .o_redirect                (o_redirect),
  .o_discard                 (o_discard),
  .o_stall                   (o_stall),
  .o_taken                   (o_taken),
  .o_ovf_flag                (o_ovf_flag),
  .i_exec_cond               (i_exec_cond),
  .i_exec_pc                 (i_exec_pc),
  .i_exec_result             (i_exec_result),
  .i_exec_src_a              (i_exec_src_a),
  .i_exec_src_b              (i_exec_src_b),
  .i_exec_mod_mask           (i_exec_mod_mask),
  .o_redirect_pc             (o_redirect_pc)
);

//--- abs_fetch.sv
// fetch stage model following the sequencer's redirects
`timescale 1ns/100ps
module abs_fetch(input wire i_clk_sys, i_sys_rst, o_redirect, o_stall,
  input wire [15:0] o_redirect_pc, output reg [15:0] o_fetch_pc);
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) o_fetch_pc <= 16'h0;
    else if (o_redirect) o_fetch_pc <= o_redirect_pc;
    else if (!o_stall) o_fetch_pc <= o_fetch_pc + 16'h1;
  end
endmodule

//--- abs_tb.sv
// self-checking bench for the alu branch sequencer
`timescale 1ns/100ps
module testbench;
  reg i_clk_sys = 0, i_sys_rst = 1, i_exec_valid = 0, i_exec_is_cmp = 0, i_exec_modulo = 0;
  reg i_exec_always_execute_bit = 0, i_exec_is_addsub = 0, i_exec_ovf = 0;
  reg [2:0] i_exec_cond = 3'h0;
  reg [15:0] i_exec_pc = 16'h0, i_exec_result = 16'h0, i_exec_src_a = 16'h0;
  reg [15:0] i_exec_src_b = 16'h0, i_exec_mod_mask = 16'hf, pc = 16'h10;
  wire o_redirect, o_discard, o_stall, o_taken, o_ovf_flag;
  wire [15:0] o_redirect_pc, o_fetch_pc;
  integer n_mismatch = 0, num_checks = 0;
  abs_seq DUT (
    .i_clk_sys                 (i_clk_sys),
    .i_sys_rst                 (i_sys_rst),
    .i_exec_valid              (i_exec_valid),
    .i_exec_pc                 (i_exec_pc),
    .i_exec_is_cmp             (i_exec_is_cmp),
    .i_exec_cond               (i_exec_cond),
    .i_exec_always_execute_bit (i_exec_always_execute_bit),
    .i_exec_result             (i_exec_result),
    .i_exec_src_a              (i_exec_src_a),
    .i_exec_src_b              (i_exec_src_b),
    .i_exec_mod_mask           (i_exec_mod_mask),
    .i_exec_is_addsub          (i_exec_is_addsub),
    .i_exec_modulo             (i_exec_modulo),
    .i_exec_ovf                (i_exec_ovf),
    .o_redirect                (o_redirect),
    .o_redirect_pc             (o_redirect_pc),
    .o_discard                 (o_discard),
    .o_stall                   (o_stall),
    .o_taken                   (o_taken),
    .o_ovf_flag                (o_ovf_flag)
  );
  abs_fetch u_fetch (
    .i_clk_sys     (i_clk_sys),
    .i_sys_rst     (i_sys_rst),
    .o_redirect    (o_redirect),
    .o_stall       (o_stall),
    .o_redirect_pc (o_redirect_pc),
    .o_fetch_pc    (o_fetch_pc)
  );
  initial forever #2 i_clk_sys = ~i_clk_sys;
  task chk(input ok); begin
    num_checks = num_checks + 1;
    if (ok !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: pc %0h", $time, pc);
    end
  end endtask
  task b(input [2:0] c, input k, e, input [15:0] v, w, input t); begin
    {i_exec_valid, i_exec_cond, i_exec_is_cmp, i_exec_always_execute_bit} = {1'b1, c, k, e};
    {i_exec_pc, i_exec_result, i_exec_src_a, i_exec_src_b} = {pc, v, v, w};
    @(negedge i_clk_sys) {i_exec_cond, i_exec_pc} = {3'h0, pc + 16'h1};
    chk(o_taken === t && o_redirect === (t | e) &&
      (!(t | e) || o_redirect_pc === pc + 16'h4));
    @(negedge i_clk_sys) i_exec_valid = 0;
    chk(o_discard === !(t | e) && o_stall === !(t | e) &&
      o_redirect === !(t | e) && (!(t | e) || o_fetch_pc === pc + 16'h4)
      && o_redirect_pc === pc + ((t | e) ? 16'h4 : 16'h2));
    @(negedge i_clk_sys);
    chk(o_discard === 1'b0 && o_stall === !(t | e) && o_redirect === (e & !t) &&
      (!(e & !t) || o_redirect_pc === pc + 16'h2));
    @(negedge i_clk_sys);
    chk(o_stall === 1'b0 && o_redirect === 1'b0 &&
      o_fetch_pc === pc + (t ? 16'h6 : 16'h2));
    @(negedge i_clk_sys);
    pc = pc + 16'h10;
  end endtask
  task print_verdict; begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  initial begin
    repeat (8) @(negedge i_clk_sys);
    {i_sys_rst, i_exec_valid} = 2'h1;
    @(negedge i_clk_sys) i_exec_valid = 0;
    chk(o_redirect === 1'b0 && o_taken === 1'b0);
    b(3'h3, 0, 0, 16'h0, 0, 1);
    b(3'h1, 0, 0, 16'h8000, 0, 1);
    b(3'h2, 0, 0, 16'h8000, 0, 0);
    b(3'h4, 0, 0, 16'h0, 0, 1);
    b(3'h5, 0, 1, 16'h0, 0, 0);
    b(3'h5, 0, 1, 16'h1, 0, 1);
    b(3'h6, 0, 0, 16'h0, 0, 1);
    {i_exec_valid, i_exec_is_addsub, i_exec_ovf} = 3'h7;
    @(negedge i_clk_sys) {i_exec_valid, i_exec_is_addsub, i_exec_ovf} = 3'h0;
    chk(o_ovf_flag === 1'b1);
    {i_exec_valid, i_exec_is_addsub, i_exec_modulo} = 3'h7;
    @(negedge i_clk_sys) {i_exec_valid, i_exec_is_addsub, i_exec_modulo} = 3'h0;
    chk(o_ovf_flag === 1'b1);
    b(3'h6, 0, 0, 16'h0, 0, 0);
    i_exec_modulo = 1;
    b(3'h3, 0, 0, 16'h1230, 0, 1);
    b(3'h5, 0, 0, 16'h1230, 0, 0);
    i_exec_modulo = 0;
    b(3'h1, 1, 0, 16'hffff, 1, 0);
    b(3'h2, 1, 0, 16'h5, 5, 1);
    b(3'h3, 1, 0, 16'h5, 5, 1);
    b(3'h4, 1, 0, 16'hffff, 1, 1);
    b(3'h5, 1, 0, 16'hffff, 1, 1);
    b(3'h6, 1, 0, 16'h5, 5, 0);
    print_verdict;
  end
endmodule
